// ==== verilog/sac_core.sv ====
// Converter control: register port, sample/approximate sequencer, compare gate
// How it works
// R1 - An 8-bit threshold compared against the high result byte when compare is on.
// R2 - Reset clears the threshold to zero.
// R3 - Threshold reads and writes as a whole byte.
// R4 - Software waits for the booster to settle before setting run.
// R5 - Run set: sample channel for a fixed time, then hold through approximation.
// R6 - First step sets bit 9 at half tap; kept if input >= tap.
// R7 - Later steps try next bit with tap from decided bits; kept if input >= tap.
// R8 - Steps continue one bit each until bit 0 is decided.
// R9 - After ten bits, copy to result and raise done pulse, compare gated.
// R10 - While run stays set, a new conversion starts right after storing.
// R11 - Clearing run aborts at once, no partial result stored.
// R12 - Mode, channel, threshold or compare writes during conversion restart it.
// R13 - In the other variant software avoids such writes during conversion.
// R14 - Compare off: done pulse after every conversion.
// R15 - Compare on, polarity 0: pulse only when high byte >= threshold.
// R16 - Compare on, polarity 1: pulse only when high byte < threshold.
// R17 - Result overwritten by every conversion regardless of the pulse.
// R18 - Channel change takes effect on the following conversion.
// R19 - Without booster, software discards the first result.
// R20 - To stop, software clears run then the booster.
// R21 - Standby halts conversion activity.
// R22 - Word view has result in upper ten bits; byte view the upper eight.
// R23 - Four-bit channel field, resets to zero, upper bits read zero.
// R24 - Mode or channel write at conversion end wins: no store, no pulse.
// R25 - Sample and steps paced by clock counters matching conversion time; step remainder dropped, so totals fall 4 to 8 clocks short.
`timescale 1ns/100ps
module sac_core
  import sac_pkg::*;
(
  input  wire logic            clk_in,        // Main clock, 25 MHz
  input  wire logic            resetn_in,     // Sync reset, low
  input  wire logic [3:0]      addr_in,       // Register address
  input  wire logic [7:0]      wdata_in,      // Write data
  input  wire logic            wr_in,         // Write strobe
  input  wire logic            rd_in,         // Read strobe
  output logic [7:0]           rdata_out,     // Read data, cycle after strobe
  input  wire logic            standby_in,    // Device in standby
  input  wire logic            cmp_above_in,  // Held input at or above tap
  output sac_pkg::sac_ana_t    ana_out,       // Sample, channel, tap
  output logic                 boost_out,     // Reference booster enable
  output logic                 done_irq_out   // Conversion done pulse
);
  import sac_pkg::*;

  typedef struct packed {
    sac_state_t  fsm;
    logic [7:0]  mode;
    logic [7:0]  chan;
    logic [7:0]  cmpm;
    logic [7:0]  thr;
    logic [9:0]  approx;
    logic [9:0]  trial;
    logic [9:0]  result;
    logic        irq;
    logic [7:0]  rdata;
    sac_ana_t    ana;
    logic        boost;
  } sac_st_t;

  sac_st_t    st;
  sac_st_t    next_st;
  sac_req_t   req;
  logic [8:0] samp_len;
  logic [8:0] step_len;
  logic [8:0] conv_len;
  logic [8:0] tmr_len;
  logic       tmr_load;
  logic       tmr_done;
  logic [7:0] res_hi;
  logic       cfg_wr;
  logic       mc_wr;
  logic       cmp_ok;
  logic       last_step;
  logic [9:0] kept;

  assign req = '{wr: wr_in, rd: rd_in, addr: addr_in, wdata: wdata_in};

  // Sample time and total conversion time from the time-select field
  always_comb
  begin
    case (st.mode[FR_LSB +: 3])
      3'h0:    begin samp_len = SAMP_T0; conv_len = CONV_T0; end
      3'h1:    begin samp_len = SAMP_T1; conv_len = CONV_T1; end
      3'h2:    begin samp_len = SAMP_T2; conv_len = CONV_T2; end
      3'h4:    begin samp_len = SAMP_T4; conv_len = CONV_T4; end
      3'h5:    begin samp_len = SAMP_T5; conv_len = CONV_T5; end
      3'h6:    begin samp_len = SAMP_T6; conv_len = CONV_T6; end
      default: begin samp_len = SAMP_T0; conv_len = CONV_T0; end
    endcase
  end

  // Steps share what is left after sampling; remainder is dropped
  assign step_len = 9'((conv_len - samp_len) / 9'(STEPS)); // R25

  // Writes that restart or cancel a running conversion
  assign cfg_wr = req.wr && (req.addr == MODE_OFS || req.addr == CHAN_OFS
                  || req.addr == CMPM_OFS || req.addr == THR_OFS);
  assign mc_wr  = req.wr && (req.addr == MODE_OFS || req.addr == CHAN_OFS);

  // Bit decision of the current step; last step when trial is bit 0
  assign kept      = cmp_above_in ? st.approx : (st.approx & ~st.trial); // R6 R7
  assign last_step = st.trial[0]; // R8
  assign res_hi    = kept[MSB_IDX -: 8];
  // Compare gate on the new high byte
  always_comb
  begin
    if (!st.cmpm[CEN_BIT])
    begin
      cmp_ok = 1'b1; // R14
    end
    else if (!st.cmpm[CPOL_BIT])
    begin
      cmp_ok = (res_hi >= st.thr); // R1 R15
    end
    else
    begin
      cmp_ok = (res_hi < st.thr); // R16
    end
  end

  // Sequencer, register writes and read mux
  always_comb
  begin
    next_st  = st;
    tmr_load = 1'b0;
    tmr_len  = samp_len;
    next_st.irq = 1'b0;
    next_st.rdata = 8'h00;
    // Register writes, whole bytes only
    if (req.wr)
    begin
      case (req.addr)
        MODE_OFS: next_st.mode = req.wdata & MODE_MASK;
        CHAN_OFS: next_st.chan = req.wdata & CHAN_MASK; // R23 R18
        CMPM_OFS: next_st.cmpm = req.wdata & CMPM_MASK;
        THR_OFS:  next_st.thr  = req.wdata; // R3
        default:  ;
      endcase
    end
    // Sequencer
    case (st.fsm)
      SAC_IDLE:
      begin
        if (next_st.mode[RUN_BIT] && !standby_in)
        begin
          next_st.fsm = SAC_SAMPLE; // R5
          tmr_load = 1'b1;
        end
      end
      SAC_SAMPLE:
      begin
        if (!next_st.mode[RUN_BIT] || standby_in)
        begin
          next_st.fsm = SAC_IDLE; // R11 R21
        end
        else if (cfg_wr)
        begin
          tmr_load = 1'b1; // R12
        end
        else if (tmr_done)
        begin
          next_st.fsm    = SAC_STEP;
          next_st.approx = 10'h200; // R6
          next_st.trial  = 10'h200;
          tmr_load = 1'b1;
          tmr_len  = step_len;
        end
      end
      SAC_STEP:
      begin
        if (!next_st.mode[RUN_BIT] || standby_in)
        begin
          next_st.fsm = SAC_IDLE; // R11 R21
        end
        else if (cfg_wr)
        begin
          next_st.fsm = SAC_SAMPLE; // R12 R24
          tmr_load = 1'b1;
        end
        else if (tmr_done)
        begin
          if (last_step)
          begin
            next_st.result = kept; // R9 R17
            next_st.irq    = cmp_ok; // R9
            next_st.fsm    = SAC_SAMPLE; // R10
            tmr_load = 1'b1;
          end
          else
          begin
            next_st.approx = kept | (st.trial >> 1); // R7
            next_st.trial  = st.trial >> 1;
            tmr_load = 1'b1;
            tmr_len  = step_len;
          end
        end
      end
      default: next_st.fsm = SAC_IDLE;
    endcase
    // Analog controls follow the next state
    next_st.ana.sample  = (next_st.fsm == SAC_SAMPLE);
    next_st.ana.channel = next_st.chan[3:0];
    next_st.ana.tap     = next_st.approx;
    next_st.boost       = next_st.mode[BOOST_BIT];
    // Read data, one cycle later
    if (req.rd)
    begin
      case (req.addr)
        MODE_OFS: next_st.rdata = st.mode;
        CHAN_OFS: next_st.rdata = st.chan;
        RESW_OFS: next_st.rdata = {st.result[1:0], RESW_PAD}; // R22
        RESH_OFS: next_st.rdata = st.result[MSB_IDX -: 8]; // R22
        CMPM_OFS: next_st.rdata = st.cmpm;
        THR_OFS:  next_st.rdata = st.thr; // R3
        STAT_OFS: next_st.rdata = {6'h00, (st.fsm == SAC_STEP),
                                   (st.fsm == SAC_SAMPLE)};
        default:  next_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      st      <= '0;
      st.fsm  <= SAC_IDLE;
      st.mode <= MODE_RST;
      st.chan <= CHAN_RST;
      st.cmpm <= CMPM_RST;
      st.thr  <= THR_RST; // R2
      st.result <= RES_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  sac_timer u_timer (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .load_in   (tmr_load),
    .len_in    (tmr_len),
    .done_out  (tmr_done)
  );

  assign rdata_out    = st.rdata;
  assign ana_out      = st.ana;
  assign boost_out    = st.boost;
  assign done_irq_out = st.irq;

  // Helper: was a conversion storing its result last cycle
  logic fin_q;
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      fin_q <= 1'b0;
    end
    else
    begin
      fin_q <= (st.fsm == SAC_STEP) && tmr_done && last_step && !cfg_wr
               && next_st.mode[RUN_BIT] && !standby_in;
    end
  end

  thr_reset_a: assert property (@(posedge clk_in) !resetn_in |=> st.thr == 8'h00) // R2
    else $error("threshold not cleared by reset");
  thr_write_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    req.wr && req.addr == THR_OFS |=> st.thr == $past(req.wdata)) // R3
    else $error("threshold write lost");
  // Hold begins: the cycle that leaves sampling for the first step
  sequence sample_to_step_s;
    st.fsm == SAC_SAMPLE ##1 st.fsm == SAC_STEP;
  endsequence

  first_bit_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    sample_to_step_s |-> st.trial == 10'h200) // R6
    else $error("first step not bit 9");
  tap_half_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    sample_to_step_s |-> ana_out.tap == 10'h200) // R6
    else $error("first tap not half scale");
  irq_only_end_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    done_irq_out |-> fin_q) // R9
    else $error("done pulse without conversion end");
  restart_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    fin_q |-> st.fsm == SAC_SAMPLE) // R10
    else $error("no restart after result");
  abort_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    st.fsm != SAC_IDLE && req.wr && req.addr == MODE_OFS && !req.wdata[RUN_BIT]
    |=> st.fsm == SAC_IDLE && $stable(st.result)) // R11
    else $error("clear of run did not abort");
  cfg_restart_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    st.fsm == SAC_STEP && req.wr && req.addr == THR_OFS |=> st.fsm == SAC_SAMPLE) // R12
    else $error("config write did not restart");
  gate_hi_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    fin_q && st.cmpm[CEN_BIT] && !st.cmpm[CPOL_BIT] && $stable(st.cmpm) && $stable(st.thr)
    |-> done_irq_out == (st.result[MSB_IDX -: 8] >= st.thr)) // R15
    else $error("compare gate high wrong");
  gate_lo_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    fin_q && st.cmpm[CEN_BIT] && st.cmpm[CPOL_BIT] && $stable(st.cmpm) && $stable(st.thr)
    |-> done_irq_out == (st.result[MSB_IDX -: 8] < st.thr)) // R16
    else $error("compare gate low wrong");
  no_cmp_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    fin_q && !st.cmpm[CEN_BIT] && $stable(st.cmpm) |-> done_irq_out) // R14
    else $error("missing done pulse");
  standby_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    standby_in |=> st.fsm == SAC_IDLE) // R21
    else $error("converter ran in standby");
  chan_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    st.chan[7:4] == 4'h0) // R23
    else $error("channel upper bits set");

  // Step, hold and pacing behaviour; a broken shift or hold shows here first
  next_bit_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    st.fsm == SAC_STEP && tmr_done && !last_step && !cfg_wr && st.mode[RUN_BIT]
    && !standby_in |=> st.trial == ($past(st.trial) >> 1)) // R7
    else $error("trial bit did not move down");
  hold_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    st.fsm == SAC_STEP |-> !ana_out.sample) // R5
    else $error("sampling during approximation");
  sample_chan_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ana_out.sample |-> ana_out.channel == st.chan[3:0]) // R18
    else $error("sampled channel differs from field");
  pace_load_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    tmr_load |=> !tmr_done) // R25
    else $error("interval ended at load");
  irq_pulse_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    done_irq_out |=> !done_irq_out) // R9
    else $error("done pulse longer than one cycle");
  cut_no_store_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    st.fsm == SAC_STEP && tmr_done && last_step && mc_wr
    |=> !done_irq_out && $stable(st.result)) // R24
    else $error("store despite colliding write");

  // Read views of result and threshold
  rd_word_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    req.rd && req.addr == RESW_OFS |=> rdata_out[5:0] == 6'h00) // R22
    else $error("word view low bits not zero");
  rd_hi_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    req.rd && req.addr == RESH_OFS |=> rdata_out == $past(st.result[MSB_IDX -: 8])) // R22
    else $error("byte view wrong");
  rd_thr_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    req.rd && req.addr == THR_OFS |=> rdata_out == $past(st.thr)) // R3
    else $error("threshold read wrong");
endmodule

// ==== verilog/sac_pkg.sv ====
// Package: register map, field layout and timing constants of the converter control
package sac_pkg;
  // Register offsets on the plain register port
  localparam logic [3:0] MODE_OFS      = 4'h0;
  localparam logic [3:0] CHAN_OFS      = 4'h1;
  localparam logic [3:0] RESW_OFS      = 4'h2;
  localparam logic [3:0] RESH_OFS      = 4'h3;
  localparam logic [3:0] CMPM_OFS      = 4'h4;
  localparam logic [3:0] THR_OFS       = 4'h5;
  localparam logic [3:0] STAT_OFS      = 4'h6;
  // Mode register fields
  localparam int RUN_BIT    = 7;
  localparam int BOOST_BIT  = 6;
  localparam int FR_LSB     = 3;
  // Compare mode fields
  localparam int CEN_BIT    = 7;
  localparam int CPOL_BIT   = 0;
  // Reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CHAN_RST = 8'h00;
  localparam logic [7:0] CMPM_RST = 8'h00;
  localparam logic [7:0] THR_RST  = 8'h00;
  localparam logic [9:0] RES_RST  = 10'h000;
  // Masks of writable bits
  localparam logic [7:0] MODE_MASK = 8'hf8;
  localparam logic [7:0] CHAN_MASK = 8'h0f;
  localparam logic [7:0] CMPM_MASK = 8'h81;
  // Result geometry
  localparam int RES_W   = 10;
  localparam int MSB_IDX = 9;
  localparam logic [5:0] RESW_PAD = 6'h00;
  // Timing: sample clocks and total conversion clocks, per conv_time_sel code
  localparam logic [8:0] SAMP_T0 = 9'h028;
  localparam logic [8:0] SAMP_T1 = 9'h020;
  localparam logic [8:0] SAMP_T2 = 9'h018;
  localparam logic [8:0] SAMP_T4 = 9'h014;
  localparam logic [8:0] SAMP_T5 = 9'h010;
  localparam logic [8:0] SAMP_T6 = 9'h00c;
  localparam logic [8:0] CONV_T0 = 9'h120;
  localparam logic [8:0] CONV_T1 = 9'h0f0;
  localparam logic [8:0] CONV_T2 = 9'h0c0;
  localparam logic [8:0] CONV_T4 = 9'h090;
  localparam logic [8:0] CONV_T5 = 9'h078;
  localparam logic [8:0] CONV_T6 = 9'h060;
  localparam logic [8:0] CNT_ONE = 9'h001;
  localparam logic [8:0] CNT_ZERO = 9'h000;
  // Number of approximation steps divides the remaining time
  localparam int STEPS = 10;

  typedef enum {SAC_IDLE, SAC_SAMPLE, SAC_STEP} sac_state_t;

  // Register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } sac_req_t;

  // Analog side request: tap, channel, hold
  typedef struct packed {
    logic       sample;
    logic [3:0] channel;
    logic [9:0] tap;
  } sac_ana_t;
endpackage

// ==== verilog/sac_timer.sv ====
// Down-counter that paces the sample interval and each approximation step
`timescale 1ns/100ps
module sac_timer
  import sac_pkg::*;
(
  input  wire logic       clk_in,     // Main clock
  input  wire logic       resetn_in,  // Sync reset, low
  input  wire logic       load_in,    // Load a new interval
  input  wire logic [8:0] len_in,     // Interval in clocks
  output logic            done_out    // Interval has run out
);
  typedef struct packed {
    logic [8:0] cnt;
    logic       done;
  } sac_tmr_t;
  sac_tmr_t st;
  sac_tmr_t next_st;

  // Count down; done is high while the count rests at one
  always_comb
  begin
    next_st = st;
    if (load_in)
    begin
      next_st.cnt = len_in;
    end
    else if (st.cnt > CNT_ONE)
    begin
      next_st.cnt = st.cnt - CNT_ONE;
    end
    next_st.done = !load_in && (next_st.cnt <= CNT_ONE);
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign done_out = st.done;
endmodule

// ==== testbench/sac_ana_model.sv ====
// Analog side model: sample-hold on per-channel levels and a comparator
`timescale 1ns/100ps
module sac_ana_model
  import sac_pkg::*;
(
  input  wire logic             clk_in,        // Main clock
  input  wire sac_pkg::sac_ana_t ana_in,       // Sample, channel, tap
  input  wire logic [15:0][9:0] volts_in,      // Level on each input
  output logic                  cmp_above_out  // Held level at or above tap
);
  logic [9:0] held  = 10'h000;
  logic       churn = 1'b0;
  // Follow the selected input while sampling, freeze it on hold
  always @(posedge clk_in)
  begin
    churn <= ~churn;
    if (ana_in.sample)
      held <= volts_in[ana_in.channel];
  end
  // No valid answer while sampling, so it churns then
  assign cmp_above_out = ana_in.sample ? churn : (held >= ana_in.tap);
endmodule

// ==== testbench/tb_top.sv ====
// Testbench: register port driver, read scoreboard, conversion scenarios
`timescale 1ns/100ps
module tb_top;
  import sac_pkg::*;
  logic             clk_in      = 1'b0;
  logic             resetn_in   = 1'b0;
  logic [3:0]       addr_in     = 4'h0;
  logic [7:0]       wdata_in    = 8'h00;
  logic             wr_in       = 1'b0;
  logic             rd_in       = 1'b0;
  logic             standby_in  = 1'b0;
  logic             rd_d        = 1'b0;
  logic [7:0]       rdata_out;
  logic             cmp_above;
  sac_ana_t         ana_out;
  logic             boost_out;
  logic             done_irq_out;
  logic [15:0][9:0] volts;
  logic [7:0]       exp_q[$];
  int               miscompares = 0;
  int               check_count = 0;

  sac_core dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .standby_in(standby_in),
    .cmp_above_in(cmp_above), .ana_out(ana_out), .boost_out(boost_out),
    .done_irq_out(done_irq_out));
  sac_ana_model ana (
    .clk_in(clk_in), .ana_in(ana_out), .volts_in(volts), .cmp_above_out(cmp_above));

  // 25 MHz clock
  always #20 clk_in = ~clk_in;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One-cycle strobes; an idle edge between calls avoids double assignment
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    exp_q.push_back(exp);
    @(posedge clk_in);
    rd_in <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge clk_in)
    rd_d <= rd_in;
  always @(negedge clk_in)
    if (rd_d)
      check(rdata_out, exp_q.pop_front());

  task automatic count_irq(input int cycles, output int n);
    n = 0;
    repeat (cycles)
    begin
      @(negedge clk_in);
      if (done_irq_out === 1'b1)
        n++;
    end
    // Back on the rising edge so later stimulus lands there
    @(posedge clk_in);
  endtask

  // Pulse must come no earlier than lo and no later than hi cycles
  task automatic wait_irq(input int lo, input int hi);
    for (int i = 0; i < hi; i++)
    begin
      @(negedge clk_in);
      if (done_irq_out === 1'b1)
      begin
        check(8'(i >= lo), 8'h01);
        return;
      end
    end
    check(8'h00, 8'h01);
    summarize();
  endtask

  initial
  begin
    int         n;
    logic [7:0] t;
    logic [7:0] h;
    logic [7:0] cm[5] = '{8'h00, 8'h80, 8'h80, 8'h81, 8'h81};
    logic [7:0] dt[5] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h01};
    int         ex[5] = '{2, 2, 0, 0, 2};
    void'($urandom(32'h65c0));
    for (int c = 0; c < 16; c++)
      volts[c] = 10'($urandom_range(1000, 8));
    repeat (10) @(posedge clk_in);
    resetn_in <= 1'b1;
    // Reset values, status idle, unmapped place reads zero
    for (int a = 0; a < 8; a++)
      reg_rd(4'(a), 8'h00);
    t = 8'($urandom);
    reg_wr(THR_OFS, t);
    reg_rd(THR_OFS, t);
    reg_wr(CHAN_OFS, 8'hf5);
    reg_rd(CHAN_OFS, 8'h05);
    // Booster first, settle time before run
    reg_wr(MODE_OFS, 8'h70);
    repeat (425) @(posedge clk_in);
    check({7'h00, boost_out}, 8'h01);
    reg_wr(MODE_OFS, 8'hf0);
    wait_irq(80, 130);
    wait_irq(80, 110);
    reg_rd(RESH_OFS, volts[5][9:2]);
    reg_rd(RESW_OFS, {volts[5][1:0], 6'h00});
    // New channel applies to the next result
    reg_wr(CHAN_OFS, 8'h0a);
    wait_irq(80, 130);
    reg_rd(RESH_OFS, volts[10][9:2]);
    // A threshold write mid-conversion restarts it
    repeat (40) @(posedge clk_in);
    reg_wr(THR_OFS, t);
    wait_irq(80, 130);
    // Compare gating at the boundary; result updates even without pulse
    for (int i = 0; i < 5; i++)
    begin
      h = volts[i][9:2];
      reg_wr(MODE_OFS, 8'h70);
      reg_wr(CHAN_OFS, 8'(i));
      reg_wr(CMPM_OFS, cm[i]);
      reg_wr(THR_OFS, h + dt[i]);
      reg_wr(MODE_OFS, 8'hf0);
      count_irq(230, n);
      check(8'(n), 8'(ex[i]));
      reg_rd(RESH_OFS, h);
    end
    // Clearing run mid-conversion keeps the old result
    reg_wr(CMPM_OFS, 8'h00);
    reg_wr(CHAN_OFS, 8'h07);
    repeat (40) @(posedge clk_in);
    reg_wr(MODE_OFS, 8'h70);
    count_irq(150, n);
    check(8'(n), 8'h00);
    reg_rd(RESH_OFS, volts[4][9:2]);
    // Standby halts conversion
    reg_wr(MODE_OFS, 8'hf0);
    repeat (30) @(posedge clk_in);
    standby_in <= 1'b1;
    count_irq(200, n);
    check(8'(n), 8'h00);
    standby_in <= 1'b0;
    // Stop run first, then the booster
    reg_wr(MODE_OFS, 8'h70);
    reg_wr(MODE_OFS, 8'h00);
    repeat (2) @(posedge clk_in);
    check({7'h00, boost_out}, 8'h00);
    summarize();
  end
endmodule
